// ---- rct_pkg.sv ----
// Constants shared by the charge-time touch sensor block.
package rct_pkg;

    // ==========================================================
    // Widths
    localparam int CNT_W = 16;
    localparam int ACC_W = 24;
    localparam int SMP_W = 8;
    localparam int PSC_W = 8;

    // ==========================================================
    // Counter settings for normal and proximity modes
    localparam logic [PSC_W-1:0] CHARGE_PRESCALE_DEF = 8'h02;
    localparam logic [CNT_W-1:0] CHARGE_LIMIT_DEF    = 16'h01FF;
    localparam logic [PSC_W-1:0] PROX_PRESCALE_DEF   = 8'h01;
    localparam logic [CNT_W-1:0] PROX_LIMIT_DEF      = 16'h0400;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int DISCHARGE_NS   = 2000;
    localparam int DISCHARGE_CYC_I = (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] DISCHARGE_CYC = DISCHARGE_CYC_I[CNT_W-1:0];

    // ==========================================================
    // Measurement sequencer states, Gray coded along the loop.
    typedef enum logic [1:0] {
        RCT_IDLE   = 2'b00,
        RCT_DISCH  = 2'b01,
        RCT_CHARGE = 2'b11,
        RCT_EVAL   = 2'b10
    } rct_state_t;

endpackage

// ---- rct_prescaler.sv ----
// Clock prescaler that gives one-cycle count enables for the charge counter.
module rct_prescaler
    import rct_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Control
    input  wire logic             clear,
    input  wire logic [PSC_W-1:0] ratio,
    // Enable out
    output logic                  tick
);

    logic [PSC_W-1:0] div_reg;
    logic [PSC_W-1:0] div_next;

    assign div_next = div_reg + 8'h01;

    // ==========================================================
    // Divider: one tick every ratio cycles, zero acts as one.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= 8'h00;
            tick    <= 1'b0;
        end else if (clear) begin
            div_reg <= 8'h00;
            tick    <= 1'b0;
        end else if (div_next >= ratio) begin
            div_reg <= 8'h00;
            tick    <= 1'b1;
        end else begin
            div_reg <= div_next;
            tick    <= 1'b0;
        end
    end

endmodule

// ---- rct_sensor.sv ----
// Charge-time touch sensor: electrode pin control, charge counter and sample accumulation.
// Functional notes
// - While idle the electrode pin is driven high as an output.
// - A measurement starts by driving the pin low to discharge the electrode.
// - After discharge the pin is released so the pull-up charges the electrode.
// - While charging the counter steps on each prescaled tick until the pin reads high.
// - On the high level the counter stops, its value is captured and the pin is discharged.
// - Touch is decided by comparing the charge time with the untouched baseline.
// - Normal mode uses its own prescaler and limit, by default 2 and 511.
// - Proximity mode uses a separate prescaler and limit, by default 1 and 1024.
// - The counter is cleared before the pin is released and steps only after release.
// - Reaching the limit before the pin goes high sets a timeout flag and ends the wait.
// - Each valid sample adds to the sum and lowers the remaining count until zero.
// - A timeout or short sets the error result and forces the remaining count to zero.
module rct_sensor
    import rct_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Measurement control
    input  wire logic             start,
    input  wire logic             proximity_mode,
    input  wire logic [SMP_W-1:0] sample_count,
    input  wire logic             sample_interrupted_marker,
    // Counter configuration
    input  wire logic [PSC_W-1:0] charge_counter_prescale,
    input  wire logic [CNT_W-1:0] charge_counter_limit,
    input  wire logic [PSC_W-1:0] proximity_counter_prescale,
    input  wire logic [CNT_W-1:0] proximity_counter_limit,
    // Touch decision
    input  wire logic [ACC_W-1:0] baseline,
    input  wire logic [ACC_W-1:0] touch_margin,
    // Electrode pin
    input  wire logic             pad_in,
    output logic                  pad_out,
    output logic                  pad_oe,
    // Status
    output logic                  busy,
    output logic                  done,
    output logic                  error,
    output logic                  timeout_flag,
    output logic                  short_flag,
    output logic                  touched,
    output logic [CNT_W-1:0]      last_count,
    output logic [ACC_W-1:0]      result
);

    rct_state_t       state_reg;
    logic             sync1_reg;
    logic             sync2_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] dis_reg;
    logic [CNT_W-1:0] limit_reg;
    logic [PSC_W-1:0] psc_reg;
    logic [SMP_W-1:0] remain_reg;
    logic [SMP_W-1:0] remain_next;
    logic [ACC_W-1:0] acc_next;
    logic [ACC_W:0]   thresh;
    logic             intr_reg;
    logic             psc_clear;
    logic             tick;
    logic             sample_bad;

    // ==========================================================
    // Pin input synchroniser.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ==========================================================
    // Prescaler runs only while charging; it is cleared during discharge.
    assign psc_clear = (state_reg != RCT_CHARGE);

    rct_prescaler u_psc (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clear   (psc_clear),
        .ratio   (psc_reg),
        .tick    (tick)
    );

    assign sample_bad  = timeout_flag | short_flag;
    assign remain_next = remain_reg - 8'h01;
    assign acc_next    = result + {{(ACC_W-CNT_W){1'b0}}, last_count};
    assign thresh      = {1'b0, baseline} + {1'b0, touch_margin};

    // ==========================================================
    // Interrupted-sample marker; a new marker wins over the clear in RCT_EVAL and is ignored in RCT_IDLE.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            intr_reg <= 1'b0;
        end else if (sample_interrupted_marker && state_reg != RCT_IDLE) begin
            intr_reg <= 1'b1;
        end else if (state_reg == RCT_EVAL || state_reg == RCT_IDLE) begin
            intr_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Sequencer, pin drive and charge counter.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= RCT_IDLE;
            pad_out      <= 1'b1;
            pad_oe       <= 1'b1;
            busy         <= 1'b0;
            done         <= 1'b0;
            error        <= 1'b0;
            timeout_flag <= 1'b0;
            short_flag   <= 1'b0;
            touched      <= 1'b0;
            count_reg    <= 16'h0000;
            dis_reg      <= 16'h0000;
            last_count   <= 16'h0000;
            limit_reg    <= CHARGE_LIMIT_DEF;
            psc_reg      <= CHARGE_PRESCALE_DEF;
            remain_reg   <= 8'h00;
            result       <= 24'h000000;
        end else begin
            done <= 1'b0;
            case (state_reg)
                RCT_IDLE: begin
                    pad_out <= 1'b1;
                    pad_oe  <= 1'b1;
                    if (start) begin
                        state_reg    <= RCT_DISCH;
                        pad_out      <= 1'b0;
                        busy         <= 1'b1;
                        error        <= 1'b0;
                        timeout_flag <= 1'b0;
                        short_flag   <= 1'b0;
                        result       <= 24'h000000;
                        dis_reg      <= 16'h0000;
                        remain_reg   <= (sample_count == 8'h00) ? 8'h01 : sample_count;
                        if (proximity_mode) begin
                            limit_reg <= proximity_counter_limit;
                            psc_reg   <= proximity_counter_prescale;
                        end else begin
                            limit_reg <= charge_counter_limit;
                            psc_reg   <= charge_counter_prescale;
                        end
                    end
                end
                RCT_DISCH: begin
                    pad_out   <= 1'b0;
                    pad_oe    <= 1'b1;
                    count_reg <= 16'h0000;
                    dis_reg   <= dis_reg + 16'h0001;
                    if (dis_reg >= DISCHARGE_CYC - 16'h0001) begin
                        if (sync2_reg) begin
                            short_flag <= 1'b1;
                            state_reg  <= RCT_EVAL;
                        end else begin
                            state_reg <= RCT_CHARGE;
                            pad_oe    <= 1'b0;
                        end
                    end
                end
                RCT_CHARGE: begin
                    pad_oe <= 1'b0;
                    if (sync2_reg) begin
                        last_count <= count_reg;
                        state_reg  <= RCT_EVAL;
                        pad_oe     <= 1'b1;
                        pad_out    <= 1'b0;
                    end else if (tick) begin
                        if (count_reg >= limit_reg) begin
                            timeout_flag <= 1'b1;
                            last_count   <= count_reg;
                            state_reg    <= RCT_EVAL;
                            pad_oe       <= 1'b1;
                            pad_out      <= 1'b0;
                        end else begin
                            count_reg <= count_reg + 16'h0001;
                        end
                    end
                end
                RCT_EVAL: begin
                    pad_oe  <= 1'b1;
                    pad_out <= 1'b0;
                    dis_reg <= 16'h0000;
                    if (sample_bad) begin
                        error      <= 1'b1;
                        remain_reg <= 8'h00;
                        touched    <= 1'b0;
                        done       <= 1'b1;
                        busy       <= 1'b0;
                        pad_out    <= 1'b1;
                        state_reg  <= RCT_IDLE;
                    end else if (intr_reg) begin
                        state_reg <= RCT_DISCH;
                    end else begin
                        result     <= acc_next;
                        remain_reg <= remain_next;
                        if (remain_next == 8'h00) begin
                            touched   <= ({1'b0, acc_next} > thresh);
                            done      <= 1'b1;
                            busy      <= 1'b0;
                            pad_out   <= 1'b1;
                            state_reg <= RCT_IDLE;
                        end else begin
                            state_reg <= RCT_DISCH;
                        end
                    end
                end
                default: begin
                    state_reg <= RCT_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks.
    a_idle_pin_high: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_IDLE && !start) |=> (pad_oe && pad_out))
        else $error("Idle pin not driven high.");

    a_start_discharge: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_IDLE && start) |=> (pad_oe && !pad_out && busy))
        else $error("Start did not drive the pin low.");

    a_charge_released: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_CHARGE) |-> !pad_oe)
        else $error("Pin driven while charging.");

    a_count_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_CHARGE && tick && !sync2_reg && count_reg < limit_reg)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("Charge counter did not step.");

    a_capture_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_CHARGE && sync2_reg)
        |=> (last_count == $past(count_reg) && state_reg == RCT_EVAL && pad_oe && !pad_out))
        else $error("Count not captured on threshold.");

    a_touch_decide: assert property (@(posedge sys_clk) disable iff (!resetn)
        (done && !error) |-> (touched == ({1'b0, result} > thresh)))
        else $error("Touch decision disagrees with sum.");

    a_mode_normal: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_IDLE && start && !proximity_mode)
        |=> (limit_reg == $past(charge_counter_limit) && psc_reg == $past(charge_counter_prescale)))
        else $error("Normal settings not taken.");

    a_mode_prox: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_IDLE && start && proximity_mode)
        |=> (limit_reg == $past(proximity_counter_limit)
             && psc_reg == $past(proximity_counter_prescale)))
        else $error("Proximity settings not taken.");

    a_count_first: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_DISCH) ##1 (state_reg == RCT_CHARGE) |-> count_reg == 16'h0000)
        else $error("Counter not cleared before release.");

    a_timeout_set: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_CHARGE && tick && !sync2_reg && count_reg >= limit_reg)
        |=> (timeout_flag && state_reg == RCT_EVAL) ##1 (error && done))
        else $error("Timeout not flagged.");

    a_sample_sum: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_EVAL && !sample_bad && !intr_reg)
        |=> (result == $past(acc_next) && remain_reg == $past(remain_reg) - 8'h01))
        else $error("Sample not accumulated.");

    a_error_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_reg == RCT_EVAL && sample_bad) |=> (error && remain_reg == 8'h00 && done))
        else $error("Error did not clear remaining count.");

    a_done_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        done |-> (!busy && state_reg == RCT_IDLE) ##1 !done)
        else $error("Completion pulse malformed.");

endmodule

// ---- rct_electrode_model.sv ----
// Electrode capacitance and pull-up resistor model for the touch sensor bench.
module rct_electrode_model
    import rct_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Pin as driven by the device
    input  wire logic             pad_out,
    input  wire logic             pad_oe,
    // Electrode behaviour
    input  wire logic [CNT_W-1:0] charge_cycles,
    input  wire logic             shorted,
    // Pin level seen by the device
    output logic                  pad_in
);
    // ==========================================================
    // Charge time since release
    logic [CNT_W-1:0] rise_cnt_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rise_cnt_reg <= '0;
        end else if (pad_oe) begin
            rise_cnt_reg <= '0;
        end else if (rise_cnt_reg != 16'hFFFF) begin
            rise_cnt_reg <= rise_cnt_reg + 16'h0001;
        end
    end

    // A released pin reads high once charged past the threshold.
    assign pad_in = shorted | (pad_oe ? pad_out : (rise_cnt_reg >= charge_cycles));
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the charge-time touch sensor.
module tb_top;
    import rct_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic             sys_clk, resetn, start, proximity_mode, sample_interrupted_marker;
    logic [SMP_W-1:0] sample_count;
    logic [PSC_W-1:0] cpsc, ppsc;
    logic [CNT_W-1:0] clim, plim, last_count, charge_cycles;
    logic [ACC_W-1:0] baseline, touch_margin, result;
    logic             pad_in, pad_out, pad_oe, busy, done, error;
    logic             timeout_flag, short_flag, touched, shorted;
    int               num_errors = 0;
    int               checked = 0;
    int               cyc;

    rct_sensor i_rct_sensor (.sys_clk(sys_clk), .resetn(resetn), .start(start),
        .proximity_mode(proximity_mode), .sample_count(sample_count),
        .sample_interrupted_marker(sample_interrupted_marker),
        .charge_counter_prescale(cpsc), .charge_counter_limit(clim),
        .proximity_counter_prescale(ppsc), .proximity_counter_limit(plim),
        .baseline(baseline), .touch_margin(touch_margin), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .busy(busy), .done(done), .error(error),
        .timeout_flag(timeout_flag), .short_flag(short_flag), .touched(touched),
        .last_count(last_count), .result(result));

    rct_electrode_model i_rct_electrode_model (.sys_clk(sys_clk), .resetn(resetn),
        .pad_out(pad_out), .pad_oe(pad_oe), .charge_cycles(charge_cycles),
        .shorted(shorted), .pad_in(pad_in));

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic kick(input logic prox, input logic [7:0] n, input logic [15:0] d,
                        input logic sh);
        proximity_mode = prox;
        sample_count = n;
        charge_cycles = d;
        shorted = sh;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
    endtask

    task automatic wait_done();
        cyc = 0;
        while (done !== 1'b1 && cyc < 5000) begin
            @(negedge sys_clk);
            cyc++;
        end
        check("done", done, 1'b1);
        shorted = 1'b0;
    endtask

    task automatic chk_count(input int d, input int p, input int n);
        int lo;
        int hi;
        lo = d / p - 1;
        hi = (d + 4) / p + 2;
        check("last_count", (last_count >= lo) && (last_count <= hi), 1);
        check("result", (result >= n * lo) && (result <= n * hi), 1);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_pin();
        check("idle_oe", pad_oe, 1'b1);
        check("idle_out", pad_out, 1'b1);
        kick(1'b0, 8'h01, 16'd60, 1'b0);
        check("disch_oe", pad_oe, 1'b1);
        check("disch_out", pad_out, 1'b0);
        check("busy_on", busy, 1'b1);
        cyc = 0;
        while (pad_oe === 1'b1 && cyc < 1000) begin
            @(negedge sys_clk);
            cyc++;
        end
        check("disch_len", cyc, DISCHARGE_CYC);
        wait_done();
        check("end_oe", pad_oe, 1'b1);
        check("busy_off", busy, 1'b0);
        check("end_out", pad_out, 1'b1);
        chk_count(60, 2, 1);
    endtask

    task automatic t_touch();
        kick(1'b0, 8'h02, 16'd60, 1'b0);
        wait_done();
        chk_count(60, 2, 2);
        check("untouched", touched, 1'b0);
        kick(1'b0, 8'h02, 16'd160, 1'b0);
        wait_done();
        chk_count(160, 2, 2);
        check("touched", touched, 1'b1);
    endtask

    task automatic t_prox();
        kick(1'b1, 8'h00, 16'd600, 1'b0);
        wait_done();
        check("prox_to", timeout_flag, 1'b0);
        chk_count(600, 1, 1);
    endtask

    task automatic t_timeout();
        cpsc = 8'h01;
        clim = 16'h0014;
        kick(1'b0, 8'h03, 16'd500, 1'b0);
        wait_done();
        check("to_flag", timeout_flag, 1'b1);
        check("to_count", last_count, 16'h0014);
        check("to_err", error, 1'b1);
        check("to_single", cyc < 2 * DISCHARGE_CYC, 1);
        check("to_touch", touched, 1'b0);
        cpsc = CHARGE_PRESCALE_DEF;
        clim = CHARGE_LIMIT_DEF;
    endtask

    task automatic t_short();
        kick(1'b0, 8'h02, 16'd60, 1'b1);
        wait_done();
        check("short", short_flag, 1'b1);
        check("short_err", error, 1'b1);
        check("short_single", cyc < 2 * DISCHARGE_CYC, 1);
    endtask

    task automatic t_interrupt();
        kick(1'b0, 8'h01, 16'd60, 1'b0);
        repeat (210) @(negedge sys_clk);
        sample_interrupted_marker = 1'b1;
        @(negedge sys_clk);
        sample_interrupted_marker = 1'b0;
        wait_done();
        check("intr_err", error, 1'b0);
        check("intr_resample", cyc > DISCHARGE_CYC, 1);
        chk_count(60, 2, 1);
    endtask

    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        {resetn, start, proximity_mode, sample_interrupted_marker, shorted} = 5'h00;
        sample_count = 8'h01;
        charge_cycles = 16'h0010;
        cpsc = CHARGE_PRESCALE_DEF;
        clim = CHARGE_LIMIT_DEF;
        ppsc = PROX_PRESCALE_DEF;
        plim = PROX_LIMIT_DEF;
        baseline = 24'h000064;
        touch_margin = 24'h00000A;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        t_pin();
        t_touch();
        t_prox();
        t_timeout();
        t_short();
        t_interrupt();
        test_done();
    end

    initial begin
        #500us;
        num_errors++;
        test_done();
    end
endmodule
